//--- user_break_match_and_trace.sv
/*
 * User break match and branch destination trace, two channels A and B.
 * Assumes all inputs come from logic on clk; the core reports only
 * instructions confirmed to execute on exec_valid, and I bus addresses
 * arrive already physical with the size and rounding the cycle really has.
 */
// The placing of the registers and the address-and-strobe port were left to the implementer.
// Overview of operation
// - Eight-entry queue of branch targets bits 27:0, shifting in each new branch
// - Entry valid bit 31 set on capture, cleared on read, trace enable, reset
// - Reset clears only valid bits, captured target bits are kept
// - Bits 30:28 of trace entries read zero; software writes zero there
// - Each channel has an 8-bit space identifier compared in its L bus conditions only
// - Any of bus, fetch/data, read/write groups at 00 disables the channel
// - A match requests a break and sets the channel's match flags
// - Channel B X/Y bus matches report through its L bus flag
// - Match flags are sticky; software writes zero to clear them
// - Simultaneous matches on both channels give a single break request unless only one of them is an after-execution break
// - I bus conditions compare cycles of every I bus master
// - I bus addresses compared are physical; software programs physical ones
// - CPU instruction fetches and fills are fetch cycles; all else data
// - I bus cycles compared with their own size and address as issued
// - Block bit set: no break taken, but flags still set on a match
// - L bus fetch, read, word or long selects fetch break; before or after
// - Fetch condition with break address bit 0 set never breaks
// - Before-execution break only on executed insns; slot breaks before branch
// - After-execution break before next insn; branch or slot defers to target
// - Untaken conditional delayed branch: next insn is not a delay slot
// - Channel B fetch conditions ignore the break data value
`timescale 1ns/100ps
`include "user_break_regs.svh"

module user_break_match_and_trace (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Register port
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [31:0]                      reg_rdata,
    // Executed instruction stream from the core
    input  wire logic                        exec_valid,
    input  wire logic [31:0]                 exec_pc,
    input  wire logic                        exec_delayed_branch,
    input  wire logic                        exec_taken,
    input  wire logic [7:0]                  cpu_asid,
    input  wire logic                        exception_block_bit,
    // L bus data accesses
    input  wire logic                        lbus_valid,
    input  wire logic [31:0]                 lbus_addr,
    input  wire logic                        lbus_write,
    input  wire user_break_pkg::size_t       lbus_size,
    input  wire logic [31:0]                 lbus_data,
    // I bus cycles of all masters
    input  wire logic                        ibus_valid,
    input  wire logic [31:0]                 ibus_addr,
    input  wire logic                        ibus_cpu,
    input  wire logic                        ibus_ifetch,
    input  wire logic                        ibus_write,
    input  wire user_break_pkg::size_t       ibus_size,
    input  wire logic [31:0]                 ibus_data,
    // X/Y memory bus
    input  wire logic                        xy_valid,
    input  wire logic                        xy_is_y,
    input  wire logic [15:0]                 xy_addr,
    input  wire logic                        xy_write,
    input  wire logic [15:0]                 xy_data,
    // Branch events
    input  wire logic                        branch_valid,
    input  wire logic [31:0]                 branch_dest,
    // Break request to the core
    output logic                             break_req,
    output user_break_pkg::break_point_t     break_point
);
    import user_break_pkg::*;

    function automatic logic cond_live(input logic [`CC_WIDTH-1:0] c);
        cond_live = (|c[`CC_BUS_I:`CC_BUS_L]) & (|c[`CC_DATA:`CC_FETCH])
                    & (|c[`CC_WRITE:`CC_READ]);
    endfunction : cond_live

    function automatic logic cycle_ok(input logic [`CC_WIDTH-1:0] c,
                                      input logic fetch, input logic wr,
                                      input size_t sz);
        logic [1:0] cs;
        cs = c[`CC_SIZE_LO+1:`CC_SIZE_LO];
        cycle_ok = (fetch ? c[`CC_FETCH] : c[`CC_DATA])
                   & (wr ? c[`CC_WRITE] : c[`CC_READ])
                   & ((cs == `SIZE_ANY) | (cs == sz));
    endfunction : cycle_ok

    // Low address bits below the access size are not compared
    function automatic logic addr_ok(input logic [31:0] bar, input logic [31:0] bam,
                                     input logic [31:0] a, input size_t sz);
        logic [31:0] care;
        care = ~bam;
        if (sz == `SIZE_LONG)
            care[1:0] = 2'h0;
        else if (sz == `SIZE_WORD)
            care[0] = 1'h0;
        addr_ok = ((bar ^ a) & care) == 32'h0;
    endfunction : addr_ok

    // Word and byte compare the low half only
    function automatic logic data_ok(input logic [31:0] bdr, input logic [31:0] bdm,
                                     input logic [31:0] d, input size_t sz);
        logic [31:0] care;
        care = ~bdm;
        if (sz != `SIZE_LONG)
            care[31:16] = 16'h0;
        data_ok = ((bdr ^ d) & care) == 32'h0;
    endfunction : data_ok

    // Registers
    logic [31:0]            bar_r [2];
    logic [31:0]            bam_r [2];
    logic [7:0]             asid_r [2];
    logic [`CC_WIDTH-1:0]   cond_r [2];
    logic [31:0]            bdr_r;
    logic [31:0]            bdm_r;
    logic [1:0]             flag_l_r;
    logic [1:0]             flag_i_r;
    logic [1:0]             after_sel_r;
    logic                   trace_en_r;
    logic [27:0]            trace_addr_r [`TRACE_DEPTH];
    logic [`TRACE_DEPTH-1:0] trace_valid_r;
    logic [`TRACE_DEPTH-1:0] trace_valid_nxt;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;
    logic                   in_slot_r;
    logic                   pend_r;
    logic                   pend_tgt_r;
    logic                   break_req_r;
    break_point_t           break_point_r;

    // Register decode
    wire       chan_sel   = reg_addr[7:5] == `CHAN_AREA;
    wire       chan_idx   = reg_addr[4];
    wire [1:0] chan_word  = reg_addr[3:2];
    wire       trace_sel  = reg_addr[7:5] == `TRACE_AREA;
    wire [2:0] trace_idx  = reg_addr[4:2];
    wire       ctrl_sel   = reg_addr == `OFF_BREAK_CONTROL;
    wire       ctrl_wr    = reg_wr & ctrl_sel;
    wire       trace_rd   = reg_rd & trace_sel;
    wire       trace_on_wr = ctrl_wr & reg_wdata[`BC_TRACE_EN];

    // Matching per channel
    logic [1:0] l_hit;
    logic [1:0] f_hit;
    logic [1:0] i_hit;
    logic [1:0] xy_hit;
    wire        i_fetch = ibus_cpu & ibus_ifetch;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            wire live   = cond_live(cond_r[ch]);
            wire on_l   = live & cond_r[ch][`CC_BUS_L];
            wire on_i   = live & cond_r[ch][`CC_BUS_I];
            wire asid_m = cpu_asid == asid_r[ch];
            wire xy_sel = (ch == 1) & cond_r[ch][`CC_XY_ENABLE];
            wire [1:0] fsz = cond_r[ch][`CC_SIZE_LO+1:`CC_SIZE_LO];
            wire fetch_sz  = (fsz == `SIZE_WORD) | (fsz == `SIZE_LONG);
            wire lsb_clear = ~bar_r[ch][0];
            wire l_data = (ch == 0) | data_ok(bdr_r, bdm_r, lbus_data, lbus_size);
            wire i_data = (ch == 0) | i_fetch
                          | data_ok(bdr_r, bdm_r, ibus_data, ibus_size);

            // L bus data access
            assign l_hit[ch] = lbus_valid & on_l & ~xy_sel & asid_m & l_data
                               & cycle_ok(cond_r[ch], 1'b0, lbus_write, lbus_size)
                               & addr_ok(bar_r[ch], bam_r[ch], lbus_addr, lbus_size);

            // L bus fetch, judged on executed instructions only, no data term
            assign f_hit[ch] = exec_valid & on_l & ~xy_sel & asid_m & fetch_sz
                               & lsb_clear
                               & cond_r[ch][`CC_FETCH] & cond_r[ch][`CC_READ]
                               & addr_ok(bar_r[ch], bam_r[ch], exec_pc, `SIZE_WORD);

            // I bus, any master, physical address as issued
            assign i_hit[ch] = ibus_valid & on_i & i_data
                               & ~(i_fetch & ~lsb_clear)
                               & cycle_ok(cond_r[ch], i_fetch, ibus_write, ibus_size)
                               & addr_ok(bar_r[ch], bam_r[ch], ibus_addr, ibus_size);

            // X/Y bus on channel B: upper half selects X, lower half Y
            if (ch == 1)
            begin : g_xy
                wire [15:0] xa = xy_is_y ? bar_r[ch][15:0] : bar_r[ch][31:16];
                wire [15:0] xm = xy_is_y ? bam_r[ch][15:0] : bam_r[ch][31:16];
                wire [15:0] xd = xy_is_y ? bdr_r[15:0] : bdr_r[31:16];
                wire [15:0] xk = xy_is_y ? bdm_r[15:0] : bdm_r[31:16];
                wire ysel = cond_r[ch][`CC_XY_SELECT_Y];
                assign xy_hit[ch] = xy_valid & on_l & xy_sel & (ysel == xy_is_y)
                                    & cycle_ok(cond_r[ch], 1'b0, xy_write, `SIZE_WORD)
                                    & (((xa ^ xy_addr) & ~xm) == 16'h0)
                                    & (((xd ^ xy_data) & ~xk) == 16'h0);
            end
            else
            begin : g_no_xy
                assign xy_hit[ch] = 1'b0;
            end
        end
    endgenerate

    // Break selection
    wire [1:0] before_hit = f_hit & ~after_sel_r;
    wire [1:0] after_hit  = f_hit & after_sel_r;
    wire       data_hit   = |(l_hit | i_hit | xy_hit);
    wire       pend_fire  = pend_r & exec_valid & ~in_slot_r;
    wire       any_fire   = (|before_hit) | pend_fire | data_hit;
    wire       pend_nxt   = (|after_hit) | (pend_r & ~pend_fire);
    wire       tgt_now    = (exec_delayed_branch & exec_taken) | in_slot_r;
    wire       pend_tgt_nxt = (|after_hit) ? tgt_now : pend_tgt_r;

    break_point_t point_nxt;
    assign point_nxt = (|before_hit) ? (in_slot_r ? BP_BEFORE_BRANCH : BP_BEFORE)
                     : pend_fire ? (pend_tgt_r ? BP_AT_TARGET : BP_AFTER)
                     : BP_AFTER;

    // Trace queue valid: read clear on the old slot, then the shift
    always_comb
    begin
        logic [`TRACE_DEPTH-1:0] v;
        v = trace_valid_r;
        if (trace_rd)
            v[trace_idx] = 1'b0;
        if (trace_on_wr)
            v = '0;
        if (branch_valid & trace_en_r)
            v = {v[`TRACE_DEPTH-2:0], 1'b1};
        trace_valid_nxt = v;
    end

    // Read mux
    always_comb
    begin
        rdata_nxt = 32'h0;
        if (chan_sel)
        begin
            unique case (chan_word)
                `OFF_BREAK_ADDRESS:   rdata_nxt = bar_r[chan_idx];
                `OFF_ADDRESS_MASK:    rdata_nxt = bam_r[chan_idx];
                `OFF_SPACE_ID:        rdata_nxt = {24'h0, asid_r[chan_idx]};
                `OFF_CYCLE_CONDITION: rdata_nxt = {22'h0, cond_r[chan_idx]};
            endcase
        end
        else if (trace_sel)
            rdata_nxt = {trace_valid_r[trace_idx], 3'h0,
                         trace_addr_r[trace_idx]};
        else if (reg_addr == `OFF_BREAK_DATA_B)
            rdata_nxt = bdr_r;
        else if (reg_addr == `OFF_DATA_MASK_B)
            rdata_nxt = bdm_r;
        else if (ctrl_sel)
            rdata_nxt = {25'h0, trace_en_r, after_sel_r,
                         flag_i_r[1], flag_l_r[1], flag_i_r[0], flag_l_r[0]};
    end

    // Configuration registers; cycle condition last written enables a channel
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int c = 0; c < 2; c++)
            begin
                bar_r[c]  <= 32'h0;
                bam_r[c]  <= 32'h0;
                asid_r[c] <= 8'h0;
                cond_r[c] <= '0;
            end
            bdr_r       <= 32'h0;
            bdm_r       <= 32'h0;
            after_sel_r <= 2'h0;
            trace_en_r  <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (chan_sel)
            begin
                unique case (chan_word)
                    `OFF_BREAK_ADDRESS:   bar_r[chan_idx]  <= reg_wdata;
                    `OFF_ADDRESS_MASK:    bam_r[chan_idx]  <= reg_wdata;
                    `OFF_SPACE_ID:        asid_r[chan_idx] <= reg_wdata[7:0];
                    `OFF_CYCLE_CONDITION: cond_r[chan_idx] <= reg_wdata[`CC_WIDTH-1:0];
                endcase
            end
            if (reg_addr == `OFF_BREAK_DATA_B)
                bdr_r <= reg_wdata;
            if (reg_addr == `OFF_DATA_MASK_B)
                bdm_r <= reg_wdata;
            if (ctrl_sel)
            begin
                after_sel_r <= reg_wdata[`BC_AFTER_EXEC_B:`BC_AFTER_EXEC_A];
                trace_en_r  <= reg_wdata[`BC_TRACE_EN];
            end
        end
    end

    // Sticky flags: a match in the clearing cycle wins, writing one keeps them
    wire [1:0] clr_l = {2{ctrl_wr}} & ~{reg_wdata[`BC_LBUS_FLAG_B], reg_wdata[`BC_LBUS_FLAG_A]};
    wire [1:0] clr_i = {2{ctrl_wr}} & ~{reg_wdata[`BC_IBUS_FLAG_B], reg_wdata[`BC_IBUS_FLAG_A]};

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flag_l_r <= 2'h0;
            flag_i_r <= 2'h0;
        end
        else
        begin
            flag_l_r <= (flag_l_r & ~clr_l) | l_hit | f_hit | xy_hit;
            flag_i_r <= (flag_i_r & ~clr_i) | i_hit;
        end
    end

    // Slot tracking, pending after-execution break and the request
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            in_slot_r     <= 1'b0;
            pend_r        <= 1'b0;
            pend_tgt_r    <= 1'b0;
            break_req_r   <= 1'b0;
            break_point_r <= BP_BEFORE;
        end
        else
        begin
            if (exec_valid)
                in_slot_r <= exec_delayed_branch & exec_taken;
            pend_r        <= pend_nxt;
            pend_tgt_r    <= pend_tgt_nxt;
            break_req_r   <= any_fire & ~exception_block_bit;
            break_point_r <= point_nxt;
        end
    end

    // Trace storage and read data; entry addresses survive reset
    always_ff @(posedge clk)
    begin
        if (branch_valid & trace_en_r)
        begin
            trace_addr_r[0] <= branch_dest[`TE_ADDR_HI:0];
            for (int e = 1; e < `TRACE_DEPTH; e++)
                trace_addr_r[e] <= trace_addr_r[e-1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            trace_valid_r <= '0;
            rdata_r       <= 32'h0;
        end
        else
        begin
            trace_valid_r <= trace_valid_nxt;
            rdata_r       <= reg_rd ? rdata_nxt : 32'h0;
        end
    end

    assign reg_rdata   = rdata_r;
    assign break_req   = break_req_r;
    assign break_point = break_point_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chan_off_a: assert property (!cond_live(cond_r[0]) |-> (l_hit[0] | f_hit[0] | i_hit[0]) == 1'b0)
        else $error("channel A matched with a zero condition group");
    space_id_match_a: assert property (l_hit[0] |-> cpu_asid == asid_r[0])
        else $error("channel A matched with a different space id");
    block_stops_a: assert property (exception_block_bit |=> !break_req)
        else $error("break requested while blocked");
    match_flag_a: assert property (l_hit[0] |=> flag_l_r[0] ##1 flag_l_r[0] || ctrl_wr || $past(ctrl_wr))
        else $error("L bus match did not set channel A flag");
    flag_sticky_a: assert property (flag_i_r[1] && !clr_i[1] |=> flag_i_r[1])
        else $error("channel B I bus flag dropped without a clear");
    single_request_a: assert property ((l_hit[0] | i_hit[0]) && (l_hit[1] | i_hit[1])
        && !exception_block_bit |=> break_req && (flag_l_r[0] | flag_i_r[0])
        && (flag_l_r[1] | flag_i_r[1]))
        else $error("dual match did not give one request and both flags");
    fetch_lsb_a: assert property (bar_r[0][0] |-> !f_hit[0])
        else $error("fetch break with address bit 0 set");
    // Entries are never reset, so the shifted copy is compared by case equality
    trace_shift_a: assert property (branch_valid && trace_en_r |=> trace_valid_r[0]
        && trace_addr_r[0] == $past(branch_dest[`TE_ADDR_HI:0])
        && trace_addr_r[1] === $past(trace_addr_r[0]))
        else $error("trace queue did not shift in the branch target");
    trace_read_a: assert property (trace_rd && !(branch_valid && trace_en_r) |=>
        !trace_valid_r[$past(trace_idx)] && reg_rdata[30:28] == 3'h0)
        else $error("trace entry read did not clear valid");

endmodule : user_break_match_and_trace

//--- user_break_regs.svh
/*
 * Register offsets, field positions and encodings of the user break
 * match and trace block.
 * Assumes a byte-addressed register port with one 32-bit word per register.
 */
`ifndef USER_BREAK_REGS_SVH
`define USER_BREAK_REGS_SVH

// Channel registers: channel in addr bit 4, register word in bits 3:2
`define OFF_BREAK_ADDRESS      2'h0
`define OFF_ADDRESS_MASK       2'h1
`define OFF_SPACE_ID           2'h2
`define OFF_CYCLE_CONDITION    2'h3
`define CHAN_AREA              3'h0
`define OFF_BREAK_DATA_B       8'h20
`define OFF_DATA_MASK_B        8'h24
`define OFF_BREAK_CONTROL      8'h28
// Eight trace entries at 0x40 + 4 * index
`define TRACE_AREA             3'h2

// Cycle condition fields
`define CC_BUS_L               0
`define CC_BUS_I               1
`define CC_FETCH               2
`define CC_DATA                3
`define CC_READ                4
`define CC_WRITE               5
`define CC_SIZE_LO             6
`define CC_XY_ENABLE           8
`define CC_XY_SELECT_Y         9
`define CC_WIDTH               10

// Size codes, shared by the condition field and the bus size inputs
`define SIZE_ANY               2'h0
`define SIZE_BYTE              2'h1
`define SIZE_WORD              2'h2
`define SIZE_LONG              2'h3

// Break control fields
`define BC_LBUS_FLAG_A         0
`define BC_IBUS_FLAG_A         1
`define BC_LBUS_FLAG_B         2
`define BC_IBUS_FLAG_B         3
`define BC_AFTER_EXEC_A        4
`define BC_AFTER_EXEC_B        5
`define BC_TRACE_EN            6

// Trace entry fields
`define TE_VALID               31
`define TE_ADDR_HI             27
`define TRACE_DEPTH            8

`endif

//--- user_break_pkg.sv
/*
 * Types of the user break match and trace block.
 * Assumes user_break_regs.svh is compiled alongside.
 */
package user_break_pkg;

    typedef logic [1:0] size_t;

    // Where the core must take the break
    typedef enum logic [1:0] {
        BP_BEFORE,
        BP_BEFORE_BRANCH,
        BP_AFTER,
        BP_AT_TARGET
    } break_point_t;

endpackage : user_break_pkg

//--- core_bus_model.sv
/* Model of the core and the bus masters around the user break block.
   Assumes one clock; the bench calls pulse right after a rising edge. */
`timescale 1ns/100ps
module core_bus_model (
    // Clock and break request
    input  wire logic            clk,
    input  wire logic            break_req,
    // Core side
    output logic                 exec_valid,
    output logic                 exec_delayed_branch,
    output logic                 exec_taken,
    output logic [7:0]           cpu_asid,
    output logic                 exception_block_bit,
    output logic                 branch_valid,
    // Bus cycles, attributes shared by L bus and I bus
    output logic                 lbus_valid,
    output logic                 ibus_valid,
    output logic [31:0]          bus_addr,
    output logic                 bus_write,
    output user_break_pkg::size_t bus_size,
    output logic                 ibus_cpu,
    output logic                 ibus_ifetch
);
    import user_break_pkg::*;
    int breaks = 0;
    initial
    begin
        {exec_valid, exec_delayed_branch, exec_taken, exception_block_bit} = 4'h0;
        {branch_valid, lbus_valid, ibus_valid, bus_write, ibus_cpu, ibus_ifetch} = 6'h0;
        bus_addr = 32'h0;
        bus_size = 2'h0;
        cpu_asid = 8'ha5;
    end
    always @(posedge clk)
        if (break_req)
            breaks <= breaks + 1;
    // Sel: b0 L bus, b1 I bus, b2 executed insn, b3 branch
    // Attr: b0 write, b2:1 size, b3 CPU fetch, b4 delayed branch, b5 taken
    task automatic pulse(input logic [3:0] sel, input logic [31:0] a, input logic [5:0] attr);
        @(posedge clk);
        {branch_valid, exec_valid, ibus_valid, lbus_valid} <= sel;
        bus_addr <= a;
        {bus_size, bus_write} <= attr[2:0];
        ibus_cpu <= attr[3];
        ibus_ifetch <= attr[3];
        {exec_taken, exec_delayed_branch} <= attr[5:4];
        @(posedge clk);
        {branch_valid, exec_valid, ibus_valid, lbus_valid} <= 4'h0;
        // Released lines must not keep the last value
        bus_addr <= ~a;
    endtask : pulse
endmodule : core_bus_model

//--- testbench.sv
/* Self-checking bench for the user break match and trace block.
   Assumes core_bus_model drives every watch input but xy_is_y, which the bench ties to 0. */
`timescale 1ns/100ps
module testbench;
    import user_break_pkg::*;
    logic         clk, reset, reg_wr, reg_rd, bus_write, ibus_cpu, ibus_ifetch, break_req;
    logic         exec_valid, exec_delayed_branch, exec_taken, exception_block_bit;
    logic         branch_valid, lbus_valid, ibus_valid;
    logic [7:0]   reg_addr, cpu_asid;
    logic [31:0]  reg_wdata, reg_rdata, bus_addr;
    size_t        bus_size;
    break_point_t break_point;
    int           num_errors = 0;
    int           checks = 0;

    user_break_match_and_trace dut (
        .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .exec_valid, .exec_pc(bus_addr), .exec_delayed_branch, .exec_taken, .cpu_asid,
        .exception_block_bit, .lbus_valid, .lbus_addr(bus_addr), .lbus_write(bus_write),
        .lbus_size(bus_size), .lbus_data(bus_addr), .ibus_valid, .ibus_addr(bus_addr),
        .ibus_cpu, .ibus_ifetch, .ibus_write(bus_write), .ibus_size(bus_size),
        .ibus_data(bus_addr), .xy_valid(lbus_valid), .xy_is_y(1'b0), .xy_addr(bus_addr[15:0]),
        .xy_write(bus_write), .xy_data(bus_addr[15:0]), .branch_valid,
        .branch_dest(bus_addr), .break_req, .break_point
    );
    core_bus_model core (
        .clk, .break_req, .exec_valid, .exec_delayed_branch, .exec_taken, .cpu_asid,
        .exception_block_bit, .branch_valid, .lbus_valid, .ibus_valid, .bus_addr,
        .bus_write, .bus_size, .ibus_cpu, .ibus_ifetch
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic print_verdict;
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd

    task automatic hit(input logic [3:0] s, input logic [31:0] a, input logic [5:0] t,
                       input logic exp);
        core.pulse(s, a, t);
        #1 check({31'h0, break_req}, {31'h0, exp});
    endtask : hit

    task automatic do_reset(input int n);
        @(posedge clk);
        reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic t_data;
        logic [31:0] dis [3] = '{32'h18, 32'h11, 32'h09};
        wr(8'h08, 32'h1a5);
        rd(8'h08, 32'ha5);
        wr(8'h18, 32'h3c);
        rd(8'h18, 32'h3c);
        rd(8'h30, 32'h0);
        wr(8'h00, 32'h1234);
        wr(8'h04, 32'hf);
        wr(8'h0c, 32'h19);
        hit(4'h1, 32'h123b, 6'h2, 1'b1);
        check({30'h0, break_point}, 32'h2);
        hit(4'h1, 32'h1334, 6'h2, 1'b0);
        rd(8'h28, 32'h1);
        wr(8'h28, 32'h0);
        rd(8'h28, 32'h0);
        wr(8'h08, 32'h5a);
        hit(4'h1, 32'h1234, 6'h2, 1'b0);
        wr(8'h08, 32'ha5);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h0c, dis[i]);
            hit(4'h1, 32'h1234, 6'h2, 1'b0);
        end
    endtask : t_data

    task automatic t_both;
        int n;
        wr(8'h0c, 32'h39);
        wr(8'h10, 32'h1234);
        wr(8'h24, 32'hffff_ffff);
        wr(8'h1c, 32'h2a);
        n = core.breaks;
        // DMA write on the I bus while the L bus also matches
        hit(4'h3, 32'h1234, 6'h7, 1'b1);
        repeat (2) @(posedge clk);
        check(32'(core.breaks - n), 32'h1);
        rd(8'h28, 32'h9);
        wr(8'h28, 32'h0);
        core.exception_block_bit <= 1'b1;
        hit(4'h3, 32'h1234, 6'h7, 1'b0);
        core.exception_block_bit <= 1'b0;
        rd(8'h28, 32'h9);
        wr(8'h28, 32'h0);
        wr(8'h1c, 32'h119);
        hit(4'h1, 32'h0, 6'h2, 1'b1);
        wr(8'h24, 32'h0);
        wr(8'h1c, 32'h16);
        hit(4'h2, 32'h1234, 6'he, 1'b1);
        rd(8'h28, 32'hc);
    endtask : t_both

    task automatic t_fetch;
        wr(8'h00, 32'h400);
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'hd5);
        hit(4'h4, 32'h400, 6'h6, 1'b1);
        check({30'h0, break_point}, 32'h0);
        wr(8'h00, 32'h401);
        hit(4'h4, 32'h400, 6'h6, 1'b0);
        wr(8'h00, 32'h400);
        wr(8'h28, 32'h10);
        hit(4'h4, 32'h400, 6'h36, 1'b0);
        hit(4'h4, 32'h402, 6'h6, 1'b0);
        hit(4'h4, 32'h800, 6'h6, 1'b1);
        check({30'h0, break_point}, 32'h3);
    endtask : t_fetch

    task automatic t_trace;
        wr(8'h28, 32'h40);
        for (int i = 0; i < 9; i++)
            core.pulse(4'h8, 32'h7000_0010 + 32'(i) * 32'h100, 6'h0);
        rd(8'h40, 32'h8000_0810);
        rd(8'h40, 32'h0000_0810);
        rd(8'h5c, 32'h8000_0110);
        wr(8'h28, 32'h40);
        rd(8'h58, 32'h0000_0210);
        core.pulse(4'h8, 32'h7000_0910, 6'h0);
        do_reset(3);
        rd(8'h40, 32'h0000_0910);
        rd(8'h28, 32'h0);
    endtask : t_trace

    initial
    begin
        {reset, reg_wr, reg_rd} = 3'b100;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        do_reset(12);
        t_data;
        t_both;
        t_fetch;
        t_trace;
        print_verdict;
    end

    // A hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
endmodule : testbench
